// File: design/afecs_pkg.sv
// package: register map, field layout, types and helpers of the channel sequencer
package afecs_pkg;

   // register byte addresses on the wishbone bus
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_SWRST = 8'h04;
   localparam logic [7:0] ADR_GAIN = 8'h08;
   localparam logic [7:0] ADR_OFFS = 8'h14;
   localparam logic [7:0] ADR_STATUS = 8'h20;
   localparam logic [7:0] CH_STRIDE = 8'h04;

   // status word bit positions
   localparam int ST_POR = 0;
   localparam int ST_MODE = 1;
   localparam int ST_SEL = 3;
   localparam int ST_OVR = 5;
   localparam int ST_FIFO = 6;

   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [7:0] OFFS_RST = 8'h80;

   localparam int RES_W = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int NUM_CH = 3;

   localparam logic [2:0] ALL_CH = 3'h7;
   localparam logic [2:0] PWR_RED_ONLY = 3'h1;
   localparam logic [1:0] CONV_EXTRA = 2'h2;
   localparam logic [1:0] LAST_BYTE = 2'h1;
   localparam logic [1:0] LAST_NIB = 2'h3;
   localparam logic [1:0] SEL_BAD = 2'h3;

   typedef enum logic [1:0] {
      AFECS_PIXEL = 2'b00,
      AFECS_MONO = 2'b01,
      AFECS_LINE = 2'b10
   } afecs_mode_t;

   typedef enum logic [1:0] {
      AFECS_RED = 2'b00,
      AFECS_GREEN = 2'b01,
      AFECS_BLUE = 2'b10
   } afecs_input_t;

   typedef struct packed {
      logic nibble_out;
      logic internal_clamp_enable;
      logic auto_cycle;
      logic [1:0] sel;
      logic mono;
      logic single_channel_mode;
   } afecs_ctrl_t;

   typedef struct packed {
      logic [7:0] gain;
      logic [7:0] offset;
   } afecs_chset_t;

   localparam int CTRL_W = $bits(afecs_ctrl_t);
   localparam afecs_ctrl_t CTRL_RST = '0;
   localparam afecs_chset_t CHSET_RST = '{gain: GAIN_RST, offset: OFFS_RST};

   function automatic afecs_input_t afecs_next_input(input afecs_input_t cur);
      afecs_input_t nxt;
      unique case (cur)
         AFECS_RED: nxt = AFECS_GREEN;
         AFECS_GREEN: nxt = AFECS_BLUE;
         default: nxt = AFECS_RED;
      endcase
      return nxt;
   endfunction : afecs_next_input

   function automatic logic [2:0] afecs_onehot(input afecs_input_t sel);
      return 3'h1 << sel;
   endfunction : afecs_onehot

   function automatic logic [2:0] afecs_chan_hit(input logic [7:0] adr, input logic [7:0] base);
      logic [2:0] hit;
      for (int i = 0; i < NUM_CH; i++)
      begin
         hit[i] = (adr == base + CH_STRIDE * 8'(i));
      end
      return hit;
   endfunction : afecs_chan_hit

endpackage : afecs_pkg

// File: design/afecs_fifo.sv
// result fifo: flip-flop storage, valid/ready on both sides
`timescale 1ns/1ns
module afecs_fifo
   import afecs_pkg::*;
#(
   parameter int W = RES_W,
   parameter int DEPTH = FIFO_DEPTH
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = cnt_r != (AW+1)'(DEPTH);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= '0;
      end
      else if (push && !pop)
      begin
         cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule : afecs_fifo

// File: design/afecs_top.sv
// channel sequencer: power-ok gate, input routing, auto-cycle, result output
`timescale 1ns/1ns

// What this block does
// - power-ok reset is low whenever either supply monitor reports low.
// - register writes are dropped while the power-ok reset is low.
// - on power-ok release every register holds its default and writes work.
// - pixel mode samples all three inputs and converts all three per pixel.
// - mono mode samples only the selected input in its own channel.
// - line mode routes the selected input into the red channel.
// - line mode powers down the green and blue channels.
// - each cycle-pin pulse steps red, green, blue, red with matching settings.
// - register writes can set any input sequence in line mode.
// - 16-bit results leave on a byte bus in 8-bit or 4-bit pieces.
// - each channel has its own 8-bit gain and 8-bit offset.
// - the cycle pin is captured at the clock edge inside each sample strobe.
// - with auto-cycle on, the clamp enable bit decides clamping, not the pin.
// - single-channel mode bit set to 1 selects line-by-line operation.
module afecs_top
   import afecs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic analogue_supply_ok,
   input wire logic digital_core_supply_ok,
   input wire logic sample_strobe,
   input wire logic clamp_or_cycle_pin,
   input wire logic out_enable_n,
   input wire logic adc_valid,
   input wire logic [RES_W-1:0] adc_result,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   output logic power_ok_reset_n,
   output logic [2:0] sample_en,
   output logic [2:0] chan_power,
   output logic route_to_red,
   output afecs_chset_t [2:0] chan_set,
   output logic clamp_en,
   output logic conv_start,
   output logic [1:0] conv_chan,
   output logic [7:0] out_data_o,
   output logic out_data_oe,
   output logic out_strobe
);
   typedef enum logic {
      SER_IDLE = 1'b0,
      SER_SHIFT = 1'b1
   } afecs_ser_t;

   logic ana_s1, ana_s2, dig_s1, dig_s2;
   logic strb_s1, strb_s2, strb_s3;
   logic pin_s1, pin_s2, oen_s1, oen_s2;
   logic power_ok_reset_n_r;
   logic rst_i;
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] rd_mux;
   logic wr_en;
   logic [2:0] gain_hit;
   logic [2:0] offs_hit;
   afecs_ctrl_t ctrl_r;
   afecs_chset_t [2:0] chs_r;
   logic ovr_r;
   logic ovr_set;
   afecs_mode_t mode;
   logic bnd;
   logic pin_cap_r;
   logic advance;
   afecs_input_t cur_sel_r;
   afecs_input_t sel_nxt;
   logic [2:0] sample_en_r;
   logic [2:0] chan_power_r;
   logic route_r;
   afecs_chset_t [2:0] chan_set_r;
   logic clamp_r;
   logic [1:0] conv_left_r;
   logic conv_start_r;
   logic [1:0] conv_chan_r;
   logic cap_valid_r;
   logic [RES_W-1:0] cap_data_r;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [RES_W-1:0] fifo_out_data;
   afecs_ser_t ser_st_r;
   logic [RES_W-1:0] word_r;
   logic [1:0] part_r;
   logic nib_r;
   logic [7:0] out_data_r;
   logic out_oe_r;
   logic out_stb_r;

   // pins and supply monitor levels are asynchronous to clk
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         {ana_s1, ana_s2, dig_s1, dig_s2} <= 4'h0;
         {strb_s1, strb_s2, strb_s3, pin_s1, pin_s2} <= 5'h00;
         {oen_s1, oen_s2} <= 2'h3;
      end
      else
      begin
         {ana_s1, ana_s2} <= {analogue_supply_ok, ana_s1};
         {dig_s1, dig_s2} <= {digital_core_supply_ok, dig_s1};
         {strb_s1, strb_s2, strb_s3} <= {sample_strobe, strb_s1, strb_s2};
         {pin_s1, pin_s2} <= {clamp_or_cycle_pin, pin_s1};
         {oen_s1, oen_s2} <= {out_enable_n, oen_s1};
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         power_ok_reset_n_r <= 1'b0;
      end
      else
      begin
         power_ok_reset_n_r <= ana_s2 & dig_s2;
      end
   end

   // all sequencer state is held at defaults while power is not good
   assign rst_i = sys_rst | ~power_ok_reset_n_r;

   assign gain_hit = afecs_chan_hit(wb_adr_i, ADR_GAIN);
   assign offs_hit = afecs_chan_hit(wb_adr_i, ADR_OFFS);
   // a write lands on the edge at which the master sees ack, as classic cycles expect
   assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0]
      & power_ok_reset_n_r;

   // writes during a power fault are still acked so the master never hangs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ack_r <= 1'b0;
         dat_r <= '0;
      end
      else
      begin
         ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
         if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r)
         begin
            dat_r <= rd_mux;
         end
      end
   end

   always_comb
   begin
      rd_mux = '0;
      if (wb_adr_i == ADR_CTRL)
      begin
         rd_mux[CTRL_W-1:0] = ctrl_r;
      end
      if (wb_adr_i == ADR_STATUS)
      begin
         rd_mux[ST_POR] = power_ok_reset_n_r;
         rd_mux[ST_MODE +: 2] = mode;
         rd_mux[ST_SEL +: 2] = cur_sel_r;
         rd_mux[ST_OVR] = ovr_r;
         rd_mux[ST_FIFO] = fifo_out_valid;
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (gain_hit[i])
         begin
            rd_mux[7:0] = chs_r[i].gain;
         end
         if (offs_hit[i])
         begin
            rd_mux[7:0] = chs_r[i].offset;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         ctrl_r <= CTRL_RST;
         chs_r <= {NUM_CH{CHSET_RST}};
      end
      else if (wr_en && wb_adr_i == ADR_SWRST)
      begin
         ctrl_r <= CTRL_RST;
         chs_r <= {NUM_CH{CHSET_RST}};
      end
      else if (wr_en)
      begin
         if (wb_adr_i == ADR_CTRL)
         begin
            ctrl_r <= afecs_ctrl_t'(wb_dat_i[CTRL_W-1:0]);
         end
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (gain_hit[i])
            begin
               chs_r[i].gain <= wb_dat_i[7:0];
            end
            if (offs_hit[i])
            begin
               chs_r[i].offset <= wb_dat_i[7:0];
            end
         end
      end
   end

   // a lost result wins over a write-one clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         ovr_r <= 1'b0;
      end
      else if (ovr_set)
      begin
         ovr_r <= 1'b1;
      end
      else if (wr_en && wb_adr_i == ADR_STATUS && wb_dat_i[ST_OVR])
      begin
         ovr_r <= 1'b0;
      end
   end

   always_comb
   begin
      if (ctrl_r.single_channel_mode)
      begin
         mode = AFECS_LINE;
      end
      else if (ctrl_r.mono)
      begin
         mode = AFECS_MONO;
      end
      else
      begin
         mode = AFECS_PIXEL;
      end
   end

   assign bnd = strb_s2 & ~strb_s3;
   assign advance = bnd & ctrl_r.auto_cycle & (mode == AFECS_LINE) & pin_s2 & ~pin_cap_r;

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         pin_cap_r <= 1'b0;
      end
      else if (bnd)
      begin
         pin_cap_r <= pin_s2;
      end
   end

   always_comb
   begin
      sel_nxt = cur_sel_r;
      if (advance)
      begin
         sel_nxt = afecs_next_input(cur_sel_r);
      end
      else if (bnd && !ctrl_r.auto_cycle)
      begin
         sel_nxt = (ctrl_r.sel == SEL_BAD) ? AFECS_RED : afecs_input_t'(ctrl_r.sel);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         cur_sel_r <= AFECS_RED;
      end
      else
      begin
         cur_sel_r <= sel_nxt;
      end
   end

   // routing and settings only move at a sample boundary, never mid-conversion
   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         sample_en_r <= ALL_CH;
         chan_power_r <= ALL_CH;
         route_r <= 1'b0;
         chan_set_r <= {NUM_CH{CHSET_RST}};
      end
      else if (bnd)
      begin
         chan_set_r <= chs_r;
         unique case (mode)
            AFECS_PIXEL:
            begin
               sample_en_r <= ALL_CH;
               chan_power_r <= ALL_CH;
               route_r <= 1'b0;
            end
            AFECS_MONO:
            begin
               sample_en_r <= afecs_onehot(sel_nxt);
               chan_power_r <= afecs_onehot(sel_nxt);
               route_r <= 1'b0;
            end
            AFECS_LINE:
            begin
               sample_en_r <= afecs_onehot(sel_nxt);
               chan_power_r <= PWR_RED_ONLY;
               route_r <= 1'b1;
               chan_set_r[AFECS_RED] <= chs_r[sel_nxt];
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         clamp_r <= 1'b0;
      end
      else if (bnd)
      begin
         clamp_r <= ctrl_r.auto_cycle ? ctrl_r.internal_clamp_enable : pin_s2;
      end
   end

   // pixel mode needs a pixel period of at least three clocks
   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         conv_left_r <= '0;
         conv_start_r <= 1'b0;
         conv_chan_r <= '0;
      end
      else if (bnd)
      begin
         conv_start_r <= 1'b1;
         if (mode == AFECS_PIXEL)
         begin
            conv_chan_r <= AFECS_RED;
            conv_left_r <= CONV_EXTRA;
         end
         else
         begin
            conv_chan_r <= (mode == AFECS_LINE) ? AFECS_RED : sel_nxt;
            conv_left_r <= '0;
         end
      end
      else if (conv_left_r != '0)
      begin
         conv_start_r <= 1'b1;
         conv_chan_r <= conv_chan_r + 2'h1;
         conv_left_r <= conv_left_r - 2'h1;
      end
      else
      begin
         conv_start_r <= 1'b0;
      end
   end

   // one holding slot; a result that finds it still full overwrites it
   assign ovr_set = adc_valid & cap_valid_r & ~fifo_in_ready;

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         cap_valid_r <= 1'b0;
         cap_data_r <= '0;
      end
      else if (adc_valid)
      begin
         cap_valid_r <= 1'b1;
         cap_data_r <= adc_result;
      end
      else if (fifo_in_ready)
      begin
         cap_valid_r <= 1'b0;
      end
   end

   afecs_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst_i),
      .in_valid(cap_valid_r),
      .in_ready(fifo_in_ready),
      .in_data(cap_data_r),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   assign fifo_out_ready = (ser_st_r == SER_IDLE) & ~oen_s2;

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         ser_st_r <= SER_IDLE;
         word_r <= '0;
         part_r <= '0;
         nib_r <= 1'b0;
         out_data_r <= '0;
         out_stb_r <= 1'b0;
      end
      else
      begin
         out_stb_r <= 1'b0;
         unique case (ser_st_r)
            SER_IDLE:
            begin
               if (fifo_out_valid && fifo_out_ready)
               begin
                  word_r <= fifo_out_data;
                  part_r <= '0;
                  nib_r <= ctrl_r.nibble_out;
                  ser_st_r <= SER_SHIFT;
               end
            end
            SER_SHIFT:
            begin
               // a disabled bus stalls the shifter and backs up the fifo
               if (!oen_s2)
               begin
                  out_stb_r <= 1'b1;
                  if (nib_r)
                  begin
                     out_data_r <= {4'h0, word_r[4 * (3 - part_r) +: 4]};
                  end
                  else
                  begin
                     out_data_r <= word_r[8 * (1 - part_r) +: 8];
                  end
                  part_r <= part_r + 2'h1;
                  if (part_r == (nib_r ? LAST_NIB : LAST_BYTE))
                  begin
                     ser_st_r <= SER_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst_i)
      begin
         out_oe_r <= 1'b0;
      end
      else
      begin
         out_oe_r <= ~oen_s2;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign power_ok_reset_n = power_ok_reset_n_r;
   assign sample_en = sample_en_r;
   assign chan_power = chan_power_r;
   assign route_to_red = route_r;
   assign chan_set = chan_set_r;
   assign clamp_en = clamp_r;
   assign conv_start = conv_start_r;
   assign conv_chan = conv_chan_r;
   assign out_data_o = out_data_r;
   assign out_data_oe = out_oe_r;
   assign out_strobe = out_stb_r;

   default clocking @(posedge clk); endclocking
   default disable iff (rst_i);

   sequence pixel_burst_s;
      conv_start_r [*3];
   endsequence

   sequence line_setup_s;
      route_r && chan_power_r == PWR_RED_ONLY;
   endsequence

   por_follow_a: assert property (disable iff (sys_rst)
      !(ana_s2 && dig_s2) |=> !power_ok_reset_n_r) else $error("power-ok not dropped");
   write_gate_a: assert property (disable iff (sys_rst)
      !power_ok_reset_n_r |=> ctrl_r == CTRL_RST && chs_r == {NUM_CH{CHSET_RST}})
      else $error("register changed during power fault");
   por_release_a: assert property ($rose(power_ok_reset_n_r) |-> ctrl_r == CTRL_RST)
      else $error("control not at default on release");
   pixel_conv_a: assert property (bnd && mode == AFECS_PIXEL |=> pixel_burst_s)
      else $error("pixel mode did not start three conversions");
   mono_route_a: assert property (bnd && mode == AFECS_MONO |=>
      sample_en_r == afecs_onehot(cur_sel_r) && !route_r) else $error("mono sampling wrong");
   line_route_a: assert property (bnd && mode == AFECS_LINE && !wr_en |=>
      line_setup_s and chan_set_r[0] == chs_r[cur_sel_r]) else $error("line routing wrong");
   line_power_a: assert property (route_r |-> chan_power_r == PWR_RED_ONLY)
      else $error("green or blue still powered");
   auto_step_a: assert property (advance |=>
      cur_sel_r == afecs_next_input($past(cur_sel_r))) else $error("auto-cycle step wrong");
   reg_seq_a: assert property (bnd && !ctrl_r.auto_cycle && ctrl_r.sel != SEL_BAD |=>
      cur_sel_r == $past(ctrl_r.sel)) else $error("register selection not applied");
   byte_out_a: assert property (out_stb_r |-> out_oe_r)
      else $error("data strobed with bus disabled");
   pin_cap_a: assert property (bnd |=> pin_cap_r == $past(pin_s2))
      else $error("cycle pin not captured");
   clamp_src_a: assert property (bnd && ctrl_r.auto_cycle |=>
      clamp_r == $past(ctrl_r.internal_clamp_enable)) else $error("clamp followed pin");
   single_mode_a: assert property (bnd && ctrl_r.single_channel_mode |=> route_r)
      else $error("single-channel bit ignored");
   reset_red_a: assert property (disable iff (sys_rst)
      !power_ok_reset_n_r |=> cur_sel_r == AFECS_RED) else $error("pointer not reset to red");
   sel_hold_a: assert property (!bnd |=> $stable(cur_sel_r))
      else $error("selection moved between boundaries");

endmodule : afecs_top

// File: verification/afecs_scan_model.sv
// scanner controller model: sample strobe, cycle pin and conversion results
`timescale 1ns/1ns
module afecs_scan_model
(
   input wire logic clk,
   output logic sample_strobe,
   output logic clamp_or_cycle_pin,
   output logic adc_valid,
   output logic [15:0] adc_result
);
   initial
   begin
      sample_strobe = 1'b0;
      clamp_or_cycle_pin = 1'b0;
      adc_valid = 1'b0;
      adc_result = 16'h0000;
   end

   // pin held across the whole strobe so the capture edge lands inside it
   task automatic strobe(input logic lvl);
      @(posedge clk);
      sample_strobe <= 1'b1;
      clamp_or_cycle_pin <= lvl;
      repeat (2) @(posedge clk);
      sample_strobe <= 1'b0;
      repeat (6) @(posedge clk);
   endtask : strobe

   task automatic result(input logic [15:0] d);
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_result <= d;
      @(posedge clk);
      adc_valid <= 1'b0;
      // stale word must not pass for fresh data
      adc_result <= ~d;
   endtask : result
endmodule : afecs_scan_model

// File: verification/test_afecs_top.sv
// self-checking bench of the channel sequencer
`timescale 1ns/1ns
module test_afecs_top
   import afecs_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ana_ok = 1'b1;
   logic dig_ok = 1'b1;
   logic oe_n = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic we = 1'b0;
   logic stb = 1'b0;
   logic cyc = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [3:0] sel_use = 4'hf;
   logic ign = 1'b0;
   logic [31:0] seed = 32'h0000f180;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, power_ok_reset_n, route_to_red, clamp_en, conv_start, out_data_oe;
   logic out_strobe, sample_strobe, clamp_or_cycle_pin, adc_valid;
   logic [2:0] sample_en, chan_power;
   afecs_chset_t [2:0] chan_set;
   logic [1:0] conv_chan;
   logic [7:0] out_data_o;
   logic [RES_W-1:0] adc_result;
   logic [7:0] outq[$];
   logic [1:0] convq[$];
   int mismatches = 0;
   int checks_done = 0;
   int tick = 0;

   afecs_scan_model u_scan (.clk(clk), .sample_strobe(sample_strobe),
      .clamp_or_cycle_pin(clamp_or_cycle_pin), .adc_valid(adc_valid), .adc_result(adc_result));

   afecs_top u_dut (.clk(clk), .sys_rst(sys_rst), .analogue_supply_ok(ana_ok),
      .digital_core_supply_ok(dig_ok), .sample_strobe(sample_strobe),
      .clamp_or_cycle_pin(clamp_or_cycle_pin), .out_enable_n(oe_n), .adc_valid(adc_valid),
      .adc_result(adc_result), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(wb_ack_o),
      .power_ok_reset_n(power_ok_reset_n), .sample_en(sample_en), .chan_power(chan_power),
      .route_to_red(route_to_red), .chan_set(chan_set), .clamp_en(clamp_en),
      .conv_start(conv_start), .conv_chan(conv_chan), .out_data_o(out_data_o),
      .out_data_oe(out_data_oe), .out_strobe(out_strobe));

   initial
   begin
      forever #50 clk = ~clk;
   end

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   function automatic logic [31:0] stv(input logic [1:0] m, input logic [1:0] s,
      input logic [1:0] fo);
      return {25'h0, fo, s, m, 1'b1};
   endfunction : stv

   task automatic results();
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= sel_use;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      sel <= 4'h0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask : rdc

   task automatic convchk(input int n, input logic [1:0] c0);
      chk("conv_left", 32'h0, 32'(convq.size()));
      for (int k = 0; k < n; k++)
         convq.push_back(c0 + 2'(k));
   endtask : convchk

   task automatic send(input logic nib);
      logic [15:0] w;
      w = {rnd(), rnd()};
      for (int j = 0; j < (nib ? 4 : 2); j++)
         outq.push_back(nib ? {4'h0, w[15-4*j -: 4]} : w[15-8*j -: 8]);
      u_scan.result(w);
   endtask : send

   always @(posedge clk)
   begin
      tick++;
      if (conv_start === 1'b1)
      begin
         if (convq.size() == 0)
            chk("conv_extra", 32'h0, 32'h1);
         else
            chk("conv_chan", 32'(convq.pop_front()), 32'(conv_chan));
      end
      if (out_strobe === 1'b1 && !ign)
      begin
         if (outq.size() == 0)
            chk("out_extra", 32'h0, 32'h1);
         else
            chk("out_data", 32'(outq.pop_front()), 32'(out_data_o));
      end
      if (tick == 20000)
      begin
         mismatches++;
         results();
      end
   end

   initial
   begin
      logic [7:0] g[3];
      logic [7:0] o[3];
      logic [1:0] sl;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdc(ADR_CTRL, 32'h0, "ctrl");
      rdc(8'hfc, 32'h0, "unmapped");
      for (int i = 0; i < 3; i++)
      begin
         g[i] = rnd();
         o[i] = rnd();
         rdc(8'(ADR_GAIN + 4 * i), 32'h0, "gain");
         rdc(8'(ADR_OFFS + 4 * i), 32'h80, "offs");
         wr(8'(ADR_GAIN + 4 * i), {24'h0, g[i]});
         wr(8'(ADR_OFFS + 4 * i), {24'h0, o[i]});
         rdc(8'(ADR_GAIN + 4 * i), {24'h0, g[i]}, "gain");
      end
      // line mode, auto-cycle, internal clamp bit on
      wr(ADR_CTRL, 32'h31);
      for (int i = 0; i < 6; i++)
      begin
         convchk(1, 2'h0);
         u_scan.strobe(i[0]);
         sl = 2'(((i + 1) / 2) % 3);
         rdc(ADR_STATUS, stv(2'h2, sl, 2'h0), "status");
         chk("route", 32'({chan_power, route_to_red, clamp_en, sample_en}),
            32'({PWR_RED_ONLY, 2'b11, 3'h1 << sl}));
         chk("red_set", 32'(chan_set[0]), 32'({g[sl], o[sl]}));
      end
      wr(ADR_CTRL, 32'h09);
      convchk(1, 2'h0);
      u_scan.strobe(1'b0);
      chk("line_sel", 32'({sample_en, chan_set[0]}), 32'({3'h4, g[2], o[2]}));
      wr(ADR_CTRL, 32'h06);
      repeat (4) @(posedge clk);
      chk("held_sel", 32'(sample_en), 32'h4);
      convchk(1, 2'h1);
      u_scan.strobe(1'b0);
      chk("mono", 32'({sample_en, route_to_red}), 32'({3'h2, 1'b0}));
      wr(ADR_CTRL, 32'h0);
      convchk(3, 2'h0);
      u_scan.strobe(1'b1);
      chk("pixel", 32'({sample_en, chan_power, clamp_en}), 32'({ALL_CH, ALL_CH, 1'b1}));
      for (int i = 0; i < 3; i++)
         chk("chan_set", 32'(chan_set[i]), 32'({g[i], o[i]}));
      convchk(3, 2'h0);
      u_scan.strobe(1'b0);
      chk("clamp", 32'(clamp_en), 32'h0);
      convchk(0, 2'h0);
      for (int k = 0; k < 4; k++)
      begin
         if (k == 2)
            wr(ADR_CTRL, 32'h40);
         send(k > 1);
         repeat (8) @(posedge clk);
      end
      oe_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk("oe", 32'(out_data_oe), 32'h0);
      for (int k = 0; k < 8; k++)
         send(1'b1);
      rdc(ADR_STATUS, stv(2'h0, 2'h0, 2'h2), "fifo_full");
      oe_n <= 1'b0;
      while (outq.size() != 0) @(posedge clk);
      chk("oe", 32'(out_data_oe), 32'h1);
      // overrun: what leaves the bus is not predicted, only the sticky flag
      ign = 1'b1;
      oe_n <= 1'b1;
      for (int k = 0; k < 12; k++)
         send(1'b0);
      outq.delete();
      rdc(ADR_STATUS, stv(2'h0, 2'h0, 2'h3), "overrun");
      oe_n <= 1'b0;
      repeat (100) @(posedge clk);
      ign = 1'b0;
      wr(ADR_STATUS, 32'h20);
      rdc(ADR_STATUS, stv(2'h0, 2'h0, 2'h0), "ovr_clear");
      for (int s = 0; s < 2; s++)
      begin
         if (s == 0)
            ana_ok <= 1'b0;
         else
            dig_ok <= 1'b0;
         repeat (4) @(posedge clk);
         chk("por", 32'(power_ok_reset_n), 32'h0);
         wr(ADR_GAIN, 32'h55);
         ana_ok <= 1'b1;
         dig_ok <= 1'b1;
         repeat (4) @(posedge clk);
         chk("por", 32'(power_ok_reset_n), 32'h1);
         rdc(ADR_GAIN, 32'h0, "gain");
         wr(ADR_SWRST, 32'h1);
      end
      wr(8'(ADR_OFFS + 4), 32'h11);
      rdc(8'(ADR_OFFS + 4), 32'h11, "offs");
      wr(ADR_SWRST, 32'h1);
      rdc(8'(ADR_OFFS + 4), 32'h80, "swrst");
      sel_use = 4'he;
      wr(8'(ADR_OFFS + 4), 32'h22);
      sel_use = 4'hf;
      rdc(8'(ADR_OFFS + 4), 32'h80, "sel_gate");
      results();
   end
endmodule : test_afecs_top
